// *** rtl/phy_diag_pkg.sv ***
package phy_diag_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [15:0] OFS_LINK_RESULTS        = 16'h0133;
  localparam logic [15:0] OFS_TDR_PEAK_POLARITY   = 16'h018A;
  localparam logic [15:0] OFS_AUTONOMY_CONTROL    = 16'h018B;
  localparam logic [15:0] OFS_POWER_STATE_REQUEST = 16'h018C;
  localparam logic [15:0] OFS_SIGNAL_NOISE_RESULT = 16'h0197;

  // ------------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------------
  localparam int POL_LSB          = 11;
  localparam int POL_W            = 4;
  localparam int AUTO_CMD_BIT     = 6;
  localparam int AUTO_RSV_LSB     = 2;
  localparam int AUTO_RSV_W       = 4;
  localparam int SLEEP_EN_BIT     = 1;
  localparam int LPS_EN_BIT       = 0;
  localparam int SLEEP_REQ_BIT    = 1;
  localparam int FORCE_NORMAL_BIT = 0;
  localparam int SNR_LSB          = 0;
  localparam int SNR_W            = 9;
  localparam int LINK_UP_BIT      = 12;

  // ------------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------------
  localparam logic [POL_W-1:0]      POL_RST          = 4'h0;
  localparam logic [SNR_W-1:0]      SNR_RST          = 9'h000;
  localparam logic [AUTO_RSV_W-1:0] AUTO_RSV_RST     = 4'h6;
  localparam logic                  SLEEP_EN_RST     = 1'b1;
  localparam logic                  LPS_EN_RST       = 1'b0;
  localparam logic                  SLEEP_REQ_RST    = 1'b0;
  localparam logic                  FORCE_NORMAL_RST = 1'b0;
  localparam logic [15:0]           RD_DATA_RST      = 16'h0000;

  // ------------------------------------------------------------------
  // strap capture phase
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    BOOT_WAIT = 1'b0,
    BOOT_DONE = 1'b1
  } boot_t;

endpackage : phy_diag_pkg

// *** rtl/capture_if.sv ***
`timescale 1ns/1ps
interface capture_if #(parameter int W = 4);
  logic         update;
  logic [W-1:0] value;
  logic [W-1:0] held;

  modport src  (output update, output value, input  held);
  modport sink (input  update, input  value, output held);
endinterface : capture_if

// *** rtl/result_capture.sv ***
`timescale 1ns/1ps
module result_capture #(
  parameter int           W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  // result path
  capture_if.sink   cap
);

  typedef struct packed {
    logic [W-1:0] held;
  } cap_state_t;

  cap_state_t s;
  cap_state_t next_s;

  // only the measuring logic moves the value; software writes never reach here
  always_comb begin
    next_s = s;
    if (cap.update) begin
      next_s.held = cap.value;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s.held <= RST;
    end else begin
      s <= next_s;
    end
  end

  assign cap.held = s.held;

endmodule : result_capture

// *** rtl/phy_diag_power_mode_regs.sv ***
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// How it works
// - polarity register bits 14..11 hold peak four..one flags, one means negative.
// - autonomy bit 6 selects autonomous operation; reset clears it and the first edge after release loads the strap.
// - autonomy command bit reads zero after its first write or read.
// - managed mode only comes from the strap at reset, never from a write.
// - after sleep negotiation go to Sleep if sleep enable set, else Standby.
// - sleep code-groups go out only while the transmission enable bit is set.
// - power-mode bit 1 set requests sleep code-group transmission.
// - power-mode bit 0 set forces the device into Normal.
// - force-normal clears on the Standby to Normal move or on a power-mode write with bit 0 zero.
// - signal-to-noise bits 8..0 hold ten times the ratio in dB.
// - link results bit 12 reads one while a valid link stands.
module phy_diag_power_mode_regs (
  // clock and reset
  input  wire logic                             mclk_i,
  input  wire logic                             resetn_i,
  // register port
  input  wire logic [15:0]                      addr_i,
  input  wire logic [15:0]                      wr_data_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  output logic      [15:0]                      rd_data_o,
  // bootstrap
  input  wire logic                             strap_autonomous_i,
  // cable-test results
  input  wire logic                             pol_update_i,
  input  wire logic [phy_diag_pkg::POL_W-1:0]   pol_value_i,
  // signal-to-noise result
  input  wire logic                             snr_update_i,
  input  wire logic [phy_diag_pkg::SNR_W-1:0]   snr_value_i,
  // link and power-state machine
  input  wire logic                             link_up_i,
  input  wire logic                             lps_done_i,
  input  wire logic                             standby_to_normal_i,
  // commands to the power-state machine
  output logic                                  autonomous_o,
  output logic                                  lps_allowed_o,
  output logic                                  lps_send_o,
  output logic                                  force_normal_o,
  output logic                                  enter_sleep_o,
  output logic                                  enter_standby_o
);
  import phy_diag_pkg::*;

  // ------------------------------------------------------------------
  // result capture
  // ------------------------------------------------------------------
  capture_if #(.W(POL_W)) pol_if ();
  capture_if #(.W(SNR_W)) snr_if ();

  assign pol_if.update = pol_update_i;
  assign pol_if.value  = pol_value_i;
  assign snr_if.update = snr_update_i;
  assign snr_if.value  = snr_value_i;

  result_capture #(.W(POL_W), .RST(POL_RST)) u_pol (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .cap      (pol_if.sink)
  );

  result_capture #(.W(SNR_W), .RST(SNR_RST)) u_snr (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .cap      (snr_if.sink)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    boot_t                 boot;
    logic                  auto_mode;
    logic                  auto_spent;
    logic [AUTO_RSV_W-1:0] auto_rsv;
    logic                  sleep_en;
    logic                  lps_en;
    logic                  sleep_req;
    logic                  force_normal;
    logic                  link_up;
    logic                  lps_send;
    logic                  goto_sleep;
    logic                  goto_standby;
    logic [15:0]           rd_data;
  } regs_t;

  regs_t s;
  regs_t next_s;

  logic wr_auto;
  logic wr_pwr;
  logic rd_auto;

  assign wr_auto = wr_i && (addr_i == OFS_AUTONOMY_CONTROL);
  assign wr_pwr  = wr_i && (addr_i == OFS_POWER_STATE_REQUEST);
  assign rd_auto = rd_i && (addr_i == OFS_AUTONOMY_CONTROL);

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // strap is taken on the first edge after release, never by the reset itself
    if (s.boot == BOOT_WAIT) begin
      next_s.boot      = BOOT_DONE;
      next_s.auto_mode = strap_autonomous_i;
    end else if (wr_auto && wr_data_i[AUTO_CMD_BIT]) begin
      next_s.auto_mode = 1'b1;  // writing zero cannot drop into managed mode
    end

    // command bit is a one-shot event on any access
    if (wr_auto || rd_auto) begin
      next_s.auto_spent = 1'b1;
    end

    if (wr_auto) begin
      next_s.auto_rsv = wr_data_i[AUTO_RSV_LSB +: AUTO_RSV_W];
      next_s.sleep_en = wr_data_i[SLEEP_EN_BIT];
      next_s.lps_en   = wr_data_i[LPS_EN_BIT];
    end

    if (wr_pwr) begin
      next_s.sleep_req = wr_data_i[SLEEP_REQ_BIT];
    end

    // a set written in the same cycle as the hardware clear wins
    if (wr_pwr && wr_data_i[FORCE_NORMAL_BIT]) begin
      next_s.force_normal = 1'b1;
    end else if (standby_to_normal_i) begin
      next_s.force_normal = 1'b0;
    end else if (wr_pwr) begin
      next_s.force_normal = 1'b0;
    end

    next_s.link_up = link_up_i;

    // sleep code-groups need both the request and the permission
    next_s.lps_send = next_s.sleep_req && next_s.lps_en;

    next_s.goto_sleep   = lps_done_i && s.sleep_en;
    next_s.goto_standby = lps_done_i && !s.sleep_en;

    // read data stands for exactly one cycle
    next_s.rd_data = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        OFS_TDR_PEAK_POLARITY: begin
          next_s.rd_data[POL_LSB +: POL_W] = pol_if.held;
        end
        OFS_AUTONOMY_CONTROL: begin
          next_s.rd_data[AUTO_CMD_BIT]                 = s.auto_mode && !s.auto_spent;
          next_s.rd_data[AUTO_RSV_LSB +: AUTO_RSV_W]   = s.auto_rsv;
          next_s.rd_data[SLEEP_EN_BIT]                 = s.sleep_en;
          next_s.rd_data[LPS_EN_BIT]                   = s.lps_en;
        end
        OFS_POWER_STATE_REQUEST: begin
          next_s.rd_data[SLEEP_REQ_BIT]    = s.sleep_req;
          next_s.rd_data[FORCE_NORMAL_BIT] = s.force_normal;
        end
        OFS_SIGNAL_NOISE_RESULT: begin
          next_s.rd_data[SNR_LSB +: SNR_W] = snr_if.held;
        end
        OFS_LINK_RESULTS: begin
          next_s.rd_data[LINK_UP_BIT] = s.link_up;
        end
        default: begin
          next_s.rd_data = 16'h0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s.boot         <= BOOT_WAIT;
      s.auto_mode    <= 1'b0;
      s.auto_spent   <= 1'b0;
      s.auto_rsv     <= AUTO_RSV_RST;
      s.sleep_en     <= SLEEP_EN_RST;
      s.lps_en       <= LPS_EN_RST;
      s.sleep_req    <= SLEEP_REQ_RST;
      s.force_normal <= FORCE_NORMAL_RST;
      s.link_up      <= 1'b0;
      s.lps_send     <= 1'b0;
      s.goto_sleep   <= 1'b0;
      s.goto_standby <= 1'b0;
      s.rd_data      <= RD_DATA_RST;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data_o       = s.rd_data;
  assign autonomous_o    = s.auto_mode;
  assign lps_allowed_o   = s.lps_en;
  assign lps_send_o      = s.lps_send;
  assign force_normal_o  = s.force_normal;
  assign enter_sleep_o   = s.goto_sleep;
  assign enter_standby_o = s.goto_standby;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence seq_auto_touch;
    (wr_i || rd_i) && (addr_i == OFS_AUTONOMY_CONTROL);
  endsequence

  sequence seq_auto_reread;
    rd_i && (addr_i == OFS_AUTONOMY_CONTROL);
  endsequence

  // strap capture is the one edge where the phase moves from wait to done
  sequence seq_boot_step;
    (s.boot == BOOT_WAIT) ##1 (s.boot == BOOT_DONE);
  endsequence

  sequence seq_snr_then_read;
    snr_update_i ##1 (rd_i && (addr_i == OFS_SIGNAL_NOISE_RESULT) && !snr_update_i);
  endsequence

  a_pol_readback: assert property (
    (rd_i && addr_i == OFS_TDR_PEAK_POLARITY) |=>
      (rd_data_o == {1'b0, $past(pol_if.held), 11'h000}))
    else $error("peak polarity readback wrong");

  a_auto_one_shot: assert property (
    seq_auto_touch ##[1:20] seq_auto_reread |=> !rd_data_o[AUTO_CMD_BIT])
    else $error("autonomy command bit read nonzero twice");

  a_strap_capture: assert property (
    seq_boot_step |-> (autonomous_o == $past(strap_autonomous_i)))
    else $error("strap not captured into autonomy mode");

  a_no_managed_write: assert property (
    (s.boot == BOOT_DONE) && autonomous_o |=> autonomous_o)
    else $error("managed mode entered after strap");

  a_sleep_select: assert property (
    lps_done_i |=> (enter_sleep_o == $past(s.sleep_en)) && (enter_standby_o != $past(s.sleep_en)))
    else $error("wrong sleep or standby selection");

  a_lps_gate: assert property (
    lps_send_o |-> lps_allowed_o)
    else $error("sleep code-groups sent without permission");

  a_lps_request: assert property (
    (wr_pwr && wr_data_i[SLEEP_REQ_BIT] && s.lps_en) |=> lps_send_o)
    else $error("sleep request did not start transmission");

  a_force_set: assert property (
    (wr_pwr && wr_data_i[FORCE_NORMAL_BIT]) |=> force_normal_o)
    else $error("force normal not set by write");

  a_force_hold: assert property (
    force_normal_o && !standby_to_normal_i && !wr_pwr |=> force_normal_o)
    else $error("force normal cleared on wrong transition");

  a_force_clear: assert property (
    force_normal_o && standby_to_normal_i && !(wr_pwr && wr_data_i[FORCE_NORMAL_BIT]) |=> !force_normal_o)
    else $error("force normal not cleared on standby to normal");

  a_snr_readback: assert property (
    seq_snr_then_read |=> (rd_data_o == {7'h00, $past(snr_value_i, 2)}))
    else $error("signal-to-noise readback wrong");

  a_link_readback: assert property (
    (rd_i && addr_i == OFS_LINK_RESULTS) |=> (rd_data_o[LINK_UP_BIT] == $past(link_up_i, 2)))
    else $error("link bit does not follow link");

  a_read_one_cycle: assert property (
    !$past(rd_i) |-> (rd_data_o == 16'h0000))
    else $error("read data outside its cycle");

  // once the strap chose managed operation, only a written one may leave it
  a_managed_stays: assert property (
    (s.boot == BOOT_DONE) && !autonomous_o && !(wr_auto && wr_data_i[AUTO_CMD_BIT]) |=> !autonomous_o)
    else $error("managed mode left without a write");

  a_lps_drop: assert property (
    (wr_auto && !wr_data_i[LPS_EN_BIT]) |=> !lps_send_o && !lps_allowed_o)
    else $error("sleep code-groups kept after permission removed");

  a_enter_cause: assert property (
    (enter_sleep_o || enter_standby_o) |-> $past(lps_done_i))
    else $error("sleep or standby pulse without negotiation");

  // results move only on the measuring strobe, never on a bus write
  a_pol_hold: assert property (
    !pol_update_i |=> $stable(pol_if.held))
    else $error("peak polarity changed without update");

  a_snr_hold: assert property (
    !snr_update_i |=> $stable(snr_if.held))
    else $error("signal-to-noise changed without update");

endmodule : phy_diag_power_mode_regs

// *** testbench/tb_phy_diag_power_mode_regs.sv ***
`timescale 1ns/1ps
module tb_phy_diag_power_mode_regs;
  import phy_diag_pkg::*;

  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        mclk_i              = 1'b0;
  logic        resetn_i            = 1'b0;
  logic [15:0] addr_i              = 16'h0000;
  logic [15:0] wr_data_i           = 16'h0000;
  logic        wr_i                = 1'b0;
  logic        rd_i                = 1'b0;
  logic [15:0] rd_data_o;
  logic        strap_autonomous_i  = 1'b1;
  logic        pol_update_i        = 1'b0;
  logic [3:0]  pol_value_i         = 4'h0;
  logic        snr_update_i        = 1'b0;
  logic [8:0]  snr_value_i         = 9'h000;
  logic        link_up_i           = 1'b0;
  logic        lps_done_i          = 1'b0;
  logic        standby_to_normal_i = 1'b0;
  logic        autonomous_o, lps_allowed_o, lps_send_o;
  logic        force_normal_o, enter_sleep_o, enter_standby_o;
  int          failures            = 0;
  int          checks_done         = 0;
  int          m_auto, m_spent, m_rsv, m_sleep, m_lps, m_req, m_fn, m_pol, m_snr, m_link;

  always #4 mclk_i = ~mclk_i;

  phy_diag_power_mode_regs uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .strap_autonomous_i(strap_autonomous_i),
    .pol_update_i(pol_update_i), .pol_value_i(pol_value_i), .snr_update_i(snr_update_i),
    .snr_value_i(snr_value_i), .link_up_i(link_up_i), .lps_done_i(lps_done_i),
    .standby_to_normal_i(standby_to_normal_i), .autonomous_o(autonomous_o),
    .lps_allowed_o(lps_allowed_o), .lps_send_o(lps_send_o), .force_normal_o(force_normal_o),
    .enter_sleep_o(enter_sleep_o), .enter_standby_o(enter_standby_o));

  // ------------------------------------------------------------------
  // model and helpers
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [15:0] exp_rd(input logic [15:0] a);
    case (a)
      OFS_TDR_PEAK_POLARITY:   exp_rd = 16'(m_pol << 11);
      OFS_AUTONOMY_CONTROL:    exp_rd = 16'(((m_auto & ~m_spent & 1) << 6) | (m_rsv << 2) | (m_sleep << 1) | m_lps);
      OFS_POWER_STATE_REQUEST: exp_rd = 16'((m_req << 1) | m_fn);
      OFS_SIGNAL_NOISE_RESULT: exp_rd = 16'(m_snr);
      OFS_LINK_RESULTS:        exp_rd = 16'(m_link << 12);
      default:                 exp_rd = 16'h0000;
    endcase
  endfunction : exp_rd

  task automatic check_outs();
    chk({12'h000, autonomous_o, lps_allowed_o, lps_send_o, force_normal_o},
        16'((m_auto << 3) | (m_lps << 2) | ((m_req & m_lps) << 1) | m_fn));
  endtask : check_outs

  task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    if (a == OFS_AUTONOMY_CONTROL) begin
      if (d[6]) m_auto = 1;
      m_spent = 1;
      m_rsv   = d[5:2];
      m_sleep = d[1];
      m_lps   = d[0];
    end
    if (a == OFS_POWER_STATE_REQUEST) begin
      m_req = d[1];
      m_fn  = d[0];
    end
    #1;
  endtask : bus_wr

  task automatic bus_rd(input logic [15:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rd_data_o, exp_rd(a));
    if (a == OFS_AUTONOMY_CONTROL) m_spent = 1;
  endtask : bus_rd

  task automatic do_reset(input logic strap);
    @(posedge mclk_i);
    resetn_i           <= 1'b0;
    strap_autonomous_i <= strap;
    repeat (16) @(posedge mclk_i);
    #1 chk({12'h000, autonomous_o, lps_allowed_o, lps_send_o, force_normal_o}, 16'h0000);
    @(posedge mclk_i);
    resetn_i <= 1'b1;
    m_auto  = int'(strap);
    m_spent = 0;
    m_rsv   = 6;
    m_sleep = 1;
    m_lps   = 0;
    m_req   = 0;
    m_fn    = 0;
    m_pol   = 0;
    m_snr   = 0;
    @(posedge mclk_i);
    #1 check_outs();
  endtask : do_reset

  task automatic lps_pulse();
    @(posedge mclk_i);
    lps_done_i <= 1'b1;
    @(posedge mclk_i);
    lps_done_i <= 1'b0;
    #1 chk({14'h0000, enter_sleep_o, enter_standby_o}, m_sleep ? 16'h0002 : 16'h0001);
    @(posedge mclk_i);
    #1 chk({14'h0000, enter_sleep_o, enter_standby_o}, 16'h0000);
    check_outs();
  endtask : lps_pulse

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'hB503));
    m_link = 0;
    do_reset(1'b1);
    bus_rd(OFS_AUTONOMY_CONTROL);
    bus_rd(OFS_AUTONOMY_CONTROL);
    bus_rd(OFS_TDR_PEAK_POLARITY);
    bus_rd(OFS_SIGNAL_NOISE_RESULT);
    bus_rd(OFS_POWER_STATE_REQUEST);
    // read-only places and an unmapped word must swallow writes
    bus_wr(OFS_TDR_PEAK_POLARITY, 16'hFFFF);
    bus_wr(OFS_SIGNAL_NOISE_RESULT, 16'hFFFF);
    bus_wr(16'h0200, 16'hFFFF);
    bus_rd(OFS_TDR_PEAK_POLARITY);
    bus_rd(OFS_SIGNAL_NOISE_RESULT);
    bus_rd(16'h0200);
    check_outs();
    // signal-to-noise is only trusted with a link, so bring one up first
    @(posedge mclk_i);
    link_up_i <= 1'b1;
    m_link = 1;
    // location bytes live outside this block; every flag is taken as valid here
    repeat (6) begin
      @(posedge mclk_i);
      pol_update_i <= 1'b1;
      snr_update_i <= 1'b1;
      m_pol = $urandom % 16;
      m_snr = $urandom % 512;
      pol_value_i <= 4'(m_pol);
      snr_value_i <= 9'(m_snr);
      @(posedge mclk_i);
      pol_update_i <= 1'b0;
      snr_update_i <= 1'b0;
      bus_rd(OFS_TDR_PEAK_POLARITY);
      bus_rd(OFS_SIGNAL_NOISE_RESULT);
    end
    for (int l = 1; l >= 0; l--) begin
      @(posedge mclk_i);
      link_up_i <= 1'(l);
      m_link = l;
      repeat (2) @(posedge mclk_i);
      bus_rd(OFS_LINK_RESULTS);
    end
    // managed mode cannot come from a write; transmission enable on, standby chosen
    bus_wr(OFS_AUTONOMY_CONTROL, 16'h0001);
    check_outs();
    bus_rd(OFS_AUTONOMY_CONTROL);
    bus_wr(OFS_POWER_STATE_REQUEST, 16'h0003);
    check_outs();
    bus_rd(OFS_POWER_STATE_REQUEST);
    lps_pulse();
    bus_wr(OFS_AUTONOMY_CONTROL, 16'h0003);
    lps_pulse();
    @(posedge mclk_i);
    standby_to_normal_i <= 1'b1;
    @(posedge mclk_i);
    standby_to_normal_i <= 1'b0;
    m_fn = 0;
    #1 check_outs();
    bus_wr(OFS_AUTONOMY_CONTROL, 16'h0002);
    check_outs();
    // second reset in mid-run, strap now selects managed operation
    do_reset(1'b0);
    bus_rd(OFS_AUTONOMY_CONTROL);
    bus_wr(OFS_AUTONOMY_CONTROL, 16'h0040);
    check_outs();
    bus_rd(OFS_AUTONOMY_CONTROL);
    give_verdict();
  end

  initial begin
    #200000;
    failures++;
    give_verdict();
  end
endmodule : tb_phy_diag_power_mode_regs
